// [pkg/btio_defines.svh]
// Constants for the block-transfer channel and its peripheral unit.
`ifndef BTIO_DEFINES_SVH
`define BTIO_DEFINES_SVH

// Word and address widths.
`define BTIO_DW        24
`define BTIO_AW        18
`define BTIO_WC_W      16
`define BTIO_SKIP_W    8
`define BTIO_SKIP_LSB  16

// Unit command word fields.
`define BTIO_CMD_BLOCK 23
`define BTIO_CMD_DIR   22
`define BTIO_CMD_UNIT  21
`define BTIO_CMD_OVR   20

// Second parameter word fields.
`define BTIO_P2_ARF    23
`define BTIO_P2_CHAIN  22

// Register byte offsets on the APB side.
`define BTIO_PA_W      8
`define BTIO_REG_ADDR_OUT 8'h00
`define BTIO_REG_CMD_OUT  8'h04
`define BTIO_REG_DATA_OUT 8'h08
`define BTIO_REG_DATA_IN  8'h0C
`define BTIO_REG_ADDR_RB  8'h10
`define BTIO_REG_PARM_RB  8'h14
`define BTIO_REG_STATUS   8'h18
`define BTIO_REG_CONFIG   8'h1C

// Status and config bit positions.
`define BTIO_ST_BUSY   0
`define BTIO_ST_REF    1
`define BTIO_ST_FSM    4
`define BTIO_CF_CHAIN  2

// Throughput figures and the clock rate.
`define BTIO_CLK_HZ     50000000
`define BTIO_UNIT_WPS   444000
`define BTIO_ILV_IN_WPS 666000
`define BTIO_SEQ_CYC    8

`endif

// [pkg/btio_pkg.sv]
// Shared types of the block-transfer channel and unit.
package btio_pkg;
  typedef enum logic [1:0] {
    BTIO_VAR_SELF = 2'h0,
    BTIO_VAR_UNIT = 2'h1,
    BTIO_VAR_ILV  = 2'h2
  } btio_var_t;

  typedef enum logic [1:0] {
    BTIO_KIND_DATA = 2'h0,
    BTIO_KIND_ADDR = 2'h1,
    BTIO_KIND_CMD  = 2'h2
  } btio_kind_t;

  typedef enum logic [3:0] {
    BTIO_S_IDLE  = 4'h0,
    BTIO_S_FWC   = 4'h1,
    BTIO_S_FTA   = 4'h2,
    BTIO_S_FCMD  = 4'h3,
    BTIO_S_FRST  = 4'h4,
    BTIO_S_RD    = 4'h5,
    BTIO_S_OHS   = 4'h6,
    BTIO_S_IWAIT = 4'h7,
    BTIO_S_WR    = 4'h8
  } btio_state_t;
endpackage

// [pkg/btio_if.sv]
// Link between the channel and up to two peripheral units.
`include "btio_defines.svh"
interface btio_if;
  // Driven per unit; each unit drives only its own index.
  wire [1:0]                     data_avail;
  wire [1:0]                     xfer_req;
  wire [1:0]                     dir_in;
  wire [1:0]                     addr_here;
  wire [1:0]                     block_mode;
  wire [1:0]                     unit_ack;
  wire [1:0][`BTIO_DW-1:0]       unit_data;
  wire [1:0][`BTIO_AW-1:0]       unit_addr;
  // Driven by the channel.
  logic [1:0]                    accepted;
  logic [1:0]                    data_here;
  logic [1:0]                    wc_done;
  logic [`BTIO_DW-1:0]           chan_data;
  btio_pkg::btio_kind_t          chan_kind;

  modport chan (
    input  data_avail, xfer_req, dir_in, addr_here, block_mode, unit_ack, unit_data,
    input  unit_addr,
    output accepted, data_here, wc_done, chan_data, chan_kind
  );
  modport unit (
    output data_avail, xfer_req, dir_in, addr_here, block_mode, unit_ack, unit_data,
    output unit_addr,
    input  accepted, data_here, wc_done, chan_data, chan_kind
  );
endinterface

// [hw/btio_channel.sv]
// Block-transfer channel: self-controlled, unit-controlled and interleaving variants.
//
// Implementation choices: register access over APB and the register addresses.
`include "btio_defines.svh"
// Contract
// - Readbacks copy address registers; unit-controlled never, interleave refuses busy.
// - Address-output prepares; command bits 23/22 start block.
// - Running self channel refuses instructions except override.
// - Start fetches two parameter words before data.
// - Output: read, bump address, count, handshake.
// - Count zero: restart flag reinitiates, else idle.
// - Input: wait, latch, accept, store, bump, repeat.
// - Chaining fetches new command, restarts like original.
// - Skip count: handshake only, no memory cycle.
// - Skip zero: store words normally again.
// - Software sends address, count, command to unit.
// - Unit request: set busy, take address, store input.
// - Unit output: read at unit address, handshake.
// - Unit-controlled busy clears after each word.
// - Unit-controlled sustains 444,000 words per second.
// - Interleave holds parameters for two units.
// - Interleave serves requests in fixed priority.
// - Block-mode line gates address and count updates.
// - Interleave output needs no handshake.
// - Interleave count-complete goes only to unit.
// - Address-here with input loads unit's address.
// - Interleave sustains 444,000 out, 666,000 in.
// - Restart flag: word after buffer reloads address.
module btio_channel #(
  parameter int AW = `BTIO_AW
) (
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`BTIO_PA_W-1:0]  paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Memory cycle stealing
  output logic                        mem_req,
  output logic                        mem_we,
  output logic [AW-1:0]               mem_addr,
  output logic [`BTIO_DW-1:0]         mem_wdata,
  input  wire logic                   mem_grant,
  input  wire logic [`BTIO_DW-1:0]    mem_rdata,
  // Link to the units
  btio_if.chan                        lnk
);
  import btio_pkg::*;

  localparam int WCW = `BTIO_WC_W;
  localparam int UNIT_CYC = `BTIO_CLK_HZ / `BTIO_UNIT_WPS;
  localparam int ILV_IN_CYC = `BTIO_CLK_HZ / `BTIO_ILV_IN_WPS;

  // The worst internal word sequence must fit the tightest word period.
  if (`BTIO_SEQ_CYC > ILV_IN_CYC || `BTIO_SEQ_CYC > UNIT_CYC) begin : g_rate_chk
    $error("Channel sequence too slow for the required word rate.");
  end
  if (AW > `BTIO_AW || AW < 8) begin : g_aw_chk
    $error("Address width not supported.");
  end

  typedef struct packed {
    btio_state_t              st;
    btio_var_t                vsel;
    logic                     chain_en;
    logic                     busy;
    logic                     refused;
    logic                     stream;
    logic                     blk;
    logic                     dir_in;
    logic                     u;
    logic                     bm;
    logic                     chain;
    logic [1:0][AW-1:0]       par;
    logic [1:0][AW-1:0]       transfer_address_register;
    logic [AW-1:0]            pa;
    logic [1:0][WCW-1:0]      wc;
    logic [1:0]               auto_restart_flag;
    logic [`BTIO_SKIP_W-1:0]  skip;
    logic [`BTIO_DW-1:0]      buf_w;
    btio_kind_t               kind;
    logic [31:0]              prdata;
    logic                     pready;
    logic                     pslverr;
    logic                     mem_req;
    logic                     mem_we;
    logic [AW-1:0]            mem_addr;
    logic [1:0]               accepted;
    logic [1:0]               data_here;
    logic [1:0]               wc_done;
  } btio_chan_t;

  btio_chan_t r_q;
  btio_chan_t r_d;

  always_comb begin
    logic          gnt;
    logic          acc;
    logic          refuse;
    logic          end_blk;
    logic          end_ilv;
    logic          k;
    logic [1:0]    dh;
    logic [WCW-1:0] wc_dec;
    r_d = r_q;
    gnt = r_q.mem_req & mem_grant;
    acc = psel & penable & r_q.pready;
    refuse = 1'b0;
    end_blk = 1'b0;
    end_ilv = 1'b0;
    k = ~lnk.xfer_req[0];
    dh = 2'h0;
    wc_dec = r_q.wc[r_q.u] - WCW'(1);
    r_d.pready = 1'b0;
    r_d.pslverr = 1'b0;
    r_d.accepted = 2'h0;
    r_d.wc_done = 2'h0;
    case (r_q.st)
      BTIO_S_IDLE: begin
        // New requests wait until the last pulse to the unit has been seen.
        if (!(|r_q.accepted) && !(|r_q.data_here)) begin
          if (r_q.vsel == BTIO_VAR_UNIT && lnk.xfer_req[0]) begin
            r_d.busy = 1'b1;
            r_d.u = 1'b0;
            r_d.transfer_address_register[0] = lnk.unit_addr[0][AW-1:0];
            if (lnk.dir_in[0]) begin
              r_d.buf_w = lnk.unit_data[0];
              r_d.accepted[0] = 1'b1;
              r_d.st = BTIO_S_WR;
            end else begin
              r_d.st = BTIO_S_RD;
            end
          end else if (r_q.vsel == BTIO_VAR_ILV && (|lnk.xfer_req)) begin
            r_d.u = k;
            r_d.bm = lnk.block_mode[k];
            if (lnk.addr_here[k] && lnk.dir_in[k]) begin
              r_d.transfer_address_register[k] = lnk.unit_addr[k][AW-1:0];
              r_d.accepted[k] = 1'b1;
            end else if (lnk.dir_in[k]) begin
              r_d.busy = 1'b1;
              r_d.buf_w = lnk.unit_data[k];
              r_d.accepted[k] = 1'b1;
              r_d.st = BTIO_S_WR;
            end else begin
              r_d.busy = 1'b1;
              r_d.st = BTIO_S_RD;
            end
          end
        end
      end
      BTIO_S_FWC: if (gnt) begin
        r_d.wc[r_q.u] = mem_rdata[WCW-1:0];
        r_d.skip = (r_q.vsel == BTIO_VAR_SELF) ?
                   mem_rdata[`BTIO_SKIP_LSB +: `BTIO_SKIP_W] : '0;
        r_d.par[r_q.u] = r_q.par[r_q.u] + AW'(1);
        r_d.st = BTIO_S_FTA;
      end
      BTIO_S_FTA: if (gnt) begin
        r_d.transfer_address_register[r_q.u] = mem_rdata[AW-1:0];
        r_d.auto_restart_flag[r_q.u] = mem_rdata[`BTIO_P2_ARF];
        r_d.chain = mem_rdata[`BTIO_P2_CHAIN];
        r_d.par[r_q.u] = r_q.par[r_q.u] + AW'(1);
        if (r_q.vsel == BTIO_VAR_ILV) begin
          r_d.busy = 1'b0;
          r_d.st = BTIO_S_IDLE;
        end else if (r_q.wc[r_q.u] == '0) begin
          end_blk = 1'b1;
        end else begin
          r_d.st = r_q.dir_in ? BTIO_S_IWAIT : BTIO_S_RD;
        end
      end
      BTIO_S_FCMD: if (gnt) begin
        r_d.buf_w = mem_rdata;
        r_d.kind = BTIO_KIND_CMD;
        r_d.blk = mem_rdata[`BTIO_CMD_BLOCK];
        r_d.dir_in = mem_rdata[`BTIO_CMD_DIR];
        r_d.par[r_q.u] = r_q.par[r_q.u] + AW'(1);
        r_d.stream = 1'b0;
        r_d.st = BTIO_S_OHS;
      end
      BTIO_S_FRST: if (gnt) begin
        r_d.par[r_q.u] = mem_rdata[AW-1:0];
        r_d.st = BTIO_S_FWC;
      end
      BTIO_S_RD: if (gnt) begin
        r_d.buf_w = mem_rdata;
        r_d.kind = BTIO_KIND_DATA;
        r_d.st = BTIO_S_OHS;
        if (r_q.vsel == BTIO_VAR_SELF) begin
          r_d.transfer_address_register[r_q.u] = r_q.transfer_address_register[r_q.u] + AW'(1);
          r_d.wc[r_q.u] = wc_dec;
        end else if (r_q.vsel == BTIO_VAR_ILV) begin
          dh[r_q.u] = 1'b1;
          r_d.st = BTIO_S_IDLE;
          r_d.busy = 1'b0;
          if (r_q.bm) begin
            r_d.transfer_address_register[r_q.u] = r_q.transfer_address_register[r_q.u] + AW'(1);
            r_d.wc[r_q.u] = wc_dec;
            end_ilv = (wc_dec == '0);
          end
        end
      end
      BTIO_S_OHS: if (lnk.unit_ack[r_q.u]) begin
        if (r_q.blk) begin
          r_d.blk = 1'b0;
          r_d.stream = 1'b1;
          r_d.st = BTIO_S_FWC;
        end else if (r_q.stream) begin
          if (r_q.wc[r_q.u] == '0) begin
            end_blk = 1'b1;
          end else begin
            r_d.st = BTIO_S_RD;
          end
        end else begin
          r_d.busy = 1'b0;
          r_d.st = BTIO_S_IDLE;
        end
      end
      BTIO_S_IWAIT: if (lnk.data_avail[0] && !r_q.accepted[0]) begin
        r_d.buf_w = lnk.unit_data[0];
        r_d.accepted[0] = 1'b1;
        if (r_q.skip != '0) begin
          r_d.skip = r_q.skip - `BTIO_SKIP_W'(1);
        end else begin
          r_d.st = BTIO_S_WR;
        end
      end
      BTIO_S_WR: if (gnt) begin
        r_d.busy = 1'b0;
        r_d.st = BTIO_S_IDLE;
        if (r_q.vsel == BTIO_VAR_SELF) begin
          r_d.busy = 1'b1;
          r_d.transfer_address_register[r_q.u] = r_q.transfer_address_register[r_q.u] + AW'(1);
          r_d.wc[r_q.u] = wc_dec;
          r_d.st = BTIO_S_IWAIT;
          end_blk = (wc_dec == '0);
        end else if (r_q.vsel == BTIO_VAR_ILV && r_q.bm) begin
          r_d.transfer_address_register[r_q.u] = r_q.transfer_address_register[r_q.u] + AW'(1);
          r_d.wc[r_q.u] = wc_dec;
          end_ilv = (wc_dec == '0);
        end
      end
      default: r_d.st = BTIO_S_IDLE;
    endcase
    if (end_blk) begin
      if (r_q.auto_restart_flag[r_q.u]) begin
        r_d.st = (r_q.chain_en && r_q.chain) ? BTIO_S_FCMD : BTIO_S_FWC;
      end else begin
        r_d.busy = 1'b0;
        r_d.stream = 1'b0;
        r_d.st = BTIO_S_IDLE;
      end
    end
    if (end_ilv) begin
      if (r_q.auto_restart_flag[r_q.u]) begin
        r_d.busy = 1'b1;
        r_d.st = BTIO_S_FRST;
      end else begin
        r_d.wc_done[r_q.u] = 1'b1;
      end
    end
    // APB: read data is prepared in the setup cycle, so pready comes one cycle later.
    if (psel && !penable) begin
      r_d.pready = 1'b1;
      r_d.prdata = 32'h0000_0000;
      case (paddr)
        `BTIO_REG_ADDR_OUT, `BTIO_REG_CMD_OUT, `BTIO_REG_DATA_OUT: ;
        `BTIO_REG_DATA_IN: r_d.prdata = 32'(r_q.buf_w);
        `BTIO_REG_ADDR_RB: r_d.prdata = 32'(r_q.transfer_address_register[r_q.u]);
        `BTIO_REG_PARM_RB: r_d.prdata = 32'(r_q.par[r_q.u]);
        `BTIO_REG_STATUS: begin
          r_d.prdata[`BTIO_ST_BUSY] = r_q.busy;
          r_d.prdata[`BTIO_ST_REF] = r_q.refused;
          r_d.prdata[`BTIO_ST_FSM +: 4] = r_q.st;
        end
        `BTIO_REG_CONFIG: r_d.prdata = 32'({r_q.chain_en, r_q.vsel});
        default: r_d.pslverr = 1'b1;
      endcase
      if ((paddr == `BTIO_REG_ADDR_RB || paddr == `BTIO_REG_PARM_RB) &&
          (r_q.vsel == BTIO_VAR_UNIT || (r_q.vsel == BTIO_VAR_ILV && r_q.busy))) begin
        r_d.prdata = 32'h0000_0000;
      end
    end
    if (acc && !r_q.pslverr) begin
      case (paddr)
        `BTIO_REG_ADDR_OUT: if (pwrite) begin
          refuse = r_q.busy;
          if (!r_q.busy && r_q.vsel == BTIO_VAR_UNIT) begin
            r_d.busy = 1'b1;
            r_d.buf_w = pwdata[`BTIO_DW-1:0];
            r_d.kind = BTIO_KIND_ADDR;
            r_d.st = BTIO_S_OHS;
          end else if (!r_q.busy) begin
            r_d.pa = pwdata[AW-1:0];
            if (r_q.vsel == BTIO_VAR_SELF) r_d.par[0] = pwdata[AW-1:0];
          end
        end
        `BTIO_REG_CMD_OUT: if (pwrite) begin
          refuse = r_q.busy && !(r_q.vsel == BTIO_VAR_SELF && pwdata[`BTIO_CMD_OVR]);
          if (!refuse) begin
            r_d.busy = 1'b1;
            r_d.buf_w = pwdata[`BTIO_DW-1:0];
            r_d.kind = BTIO_KIND_CMD;
            r_d.stream = 1'b0;
            r_d.blk = 1'b0;
            r_d.st = BTIO_S_OHS;
            if (r_q.vsel == BTIO_VAR_SELF) begin
              r_d.u = 1'b0;
              r_d.par[0] = r_q.pa;
              r_d.blk = pwdata[`BTIO_CMD_BLOCK];
              r_d.dir_in = pwdata[`BTIO_CMD_DIR];
            end else if (r_q.vsel == BTIO_VAR_ILV) begin
              r_d.u = pwdata[`BTIO_CMD_UNIT];
              r_d.par[pwdata[`BTIO_CMD_UNIT]] = r_q.pa;
              r_d.st = pwdata[`BTIO_CMD_BLOCK] ? BTIO_S_FWC : BTIO_S_IDLE;
              r_d.busy = pwdata[`BTIO_CMD_BLOCK];
            end
          end
        end
        `BTIO_REG_DATA_OUT: if (pwrite) begin
          refuse = r_q.busy;
          if (!r_q.busy) begin
            r_d.busy = 1'b1;
            r_d.buf_w = pwdata[`BTIO_DW-1:0];
            r_d.kind = BTIO_KIND_DATA;
            r_d.st = BTIO_S_OHS;
          end
        end
        `BTIO_REG_DATA_IN: if (!pwrite) refuse = r_q.busy;
        `BTIO_REG_ADDR_RB, `BTIO_REG_PARM_RB: if (!pwrite) begin
          refuse = r_q.vsel == BTIO_VAR_UNIT || (r_q.vsel == BTIO_VAR_ILV && r_q.busy);
        end
        `BTIO_REG_CONFIG: if (pwrite && !r_q.busy) begin
          r_d.vsel = btio_var_t'(pwdata[1:0]);
          r_d.chain_en = pwdata[`BTIO_CF_CHAIN];
        end
        default: ;
      endcase
      if (paddr != `BTIO_REG_STATUS && paddr != `BTIO_REG_CONFIG) begin
        r_d.refused = refuse;
      end
    end
    r_d.mem_req = r_d.st inside {BTIO_S_FWC, BTIO_S_FTA, BTIO_S_FCMD, BTIO_S_FRST,
                                 BTIO_S_RD, BTIO_S_WR};
    r_d.mem_we = (r_d.st == BTIO_S_WR);
    r_d.mem_addr = (r_d.st inside {BTIO_S_FWC, BTIO_S_FTA, BTIO_S_FCMD}) ?
                   r_d.par[r_d.u] : r_d.transfer_address_register[r_d.u];
    r_d.data_here = (r_d.st == BTIO_S_OHS) ? {r_d.u, ~r_d.u} : dh;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign prdata = r_q.prdata;
  assign pready = r_q.pready;
  assign pslverr = r_q.pslverr;
  assign mem_req = r_q.mem_req;
  assign mem_we = r_q.mem_we;
  assign mem_addr = r_q.mem_addr;
  assign mem_wdata = r_q.buf_w;
  assign lnk.accepted = r_q.accepted;
  assign lnk.data_here = r_q.data_here;
  assign lnk.wc_done = r_q.wc_done;
  assign lnk.chan_data = r_q.buf_w;
  assign lnk.chan_kind = r_q.kind;
endmodule // btio_channel

// [hw/btio_unit.sv]
// Peripheral unit controller end of the block-transfer link.
`include "btio_defines.svh"
module btio_unit #(
  parameter int ID = 0
) (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // Mode: which channel variant this unit is attached to
  input  wire btio_pkg::btio_var_t   ctl_mode,
  input  wire logic                  req_out,
  input  wire logic                  blk_mode,
  input  wire logic                  ext_addr_valid,
  input  wire logic [`BTIO_AW-1:0]   ext_addr,
  // Words from the user toward the channel
  input  wire logic                  tx_valid,
  input  wire logic [`BTIO_DW-1:0]   tx_data,
  output logic                       tx_ready,
  // Words from the channel toward the user
  output logic                       rx_valid,
  output logic [`BTIO_DW-1:0]        rx_data,
  output btio_pkg::btio_kind_t       rx_kind,
  output logic                       wc_done,
  // Link to the channel
  btio_if.unit                       lnk
);
  import btio_pkg::*;

  if (ID < 0 || ID > 1) begin : g_id_chk
    $error("Unit index must be 0 or 1.");
  end

  typedef struct packed {
    logic                  pend;
    logic [`BTIO_DW-1:0]   txd;
    logic                  ah_pend;
    logic [`BTIO_AW-1:0]   ah_addr;
    logic                  avail;
    logic                  req;
    logic                  dir;
    logic                  ah;
    logic                  ack;
    logic                  rxv;
    logic [`BTIO_DW-1:0]   rxd;
    btio_kind_t            rxk;
    logic [`BTIO_AW-1:0]   ta;
    logic [`BTIO_WC_W-1:0] wc;
    logic                  done;
  } btio_unit_t;

  btio_unit_t u_q;
  btio_unit_t u_d;

  always_comb begin
    logic acc;
    logic dh;
    logic xfer;
    u_d = u_q;
    acc = lnk.accepted[ID];
    dh = lnk.data_here[ID] && !u_q.ack;
    xfer = 1'b0;
    u_d.ack = 1'b0;
    u_d.rxv = 1'b0;
    u_d.done = (ctl_mode == BTIO_VAR_ILV) && lnk.wc_done[ID];
    if (tx_valid && !u_q.pend) begin
      u_d.pend = 1'b1;
      u_d.txd = tx_data;
    end
    if (ext_addr_valid && !u_q.ah_pend) begin
      u_d.ah_pend = 1'b1;
      u_d.ah_addr = ext_addr;
    end
    if (acc && (u_q.avail || (u_q.req && u_q.dir))) begin
      if (u_q.ah) begin
        u_d.ah_pend = 1'b0;
      end else begin
        u_d.pend = 1'b0;
        xfer = u_q.req;
      end
    end
    if (dh) begin
      u_d.rxv = 1'b1;
      u_d.rxd = lnk.chan_data;
      u_d.rxk = lnk.chan_kind;
      u_d.ack = (ctl_mode != BTIO_VAR_ILV);
      xfer = u_q.req;
      if (ctl_mode == BTIO_VAR_UNIT && !u_q.req) begin
        if (lnk.chan_kind == BTIO_KIND_ADDR) u_d.ta = lnk.chan_data[`BTIO_AW-1:0];
        if (lnk.chan_kind == BTIO_KIND_DATA) u_d.wc = lnk.chan_data[`BTIO_WC_W-1:0];
      end
    end
    // The unit keeps its own address and count in unit-controlled mode, where the channel does not.
    if (xfer && ctl_mode == BTIO_VAR_UNIT) begin
      u_d.ta = u_q.ta + `BTIO_AW'(1);
      u_d.wc = u_q.wc - `BTIO_WC_W'(1);
      u_d.done = (u_q.wc == `BTIO_WC_W'(1));
    end
    u_d.avail = (ctl_mode == BTIO_VAR_SELF) && u_d.pend;
    // A request is dropped for one cycle after each answer so it is not served twice.
    if (u_q.req && (acc || dh || xfer)) begin
      u_d.req = 1'b0;
    end else if (!u_q.req || ctl_mode == BTIO_VAR_SELF) begin
      u_d.req = 1'b0;
      u_d.ah = 1'b0;
      u_d.dir = 1'b0;
      if (ctl_mode == BTIO_VAR_ILV && u_d.ah_pend) begin
        u_d.req = 1'b1;
        u_d.ah = 1'b1;
        u_d.dir = 1'b1;
      end else if (ctl_mode != BTIO_VAR_SELF && u_d.pend &&
                   (ctl_mode == BTIO_VAR_ILV || u_q.wc != '0)) begin
        u_d.req = 1'b1;
        u_d.dir = 1'b1;
      end else if (ctl_mode != BTIO_VAR_SELF && req_out &&
                   (ctl_mode == BTIO_VAR_ILV || u_q.wc != '0)) begin
        u_d.req = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      u_q <= '0;
    end else begin
      u_q <= u_d;
    end
  end

  assign tx_ready = ~u_q.pend;
  assign rx_valid = u_q.rxv;
  assign rx_data = u_q.rxd;
  assign rx_kind = u_q.rxk;
  assign wc_done = u_q.done;
  assign lnk.data_avail[ID] = u_q.avail;
  assign lnk.xfer_req[ID] = u_q.req;
  assign lnk.dir_in[ID] = u_q.dir;
  assign lnk.addr_here[ID] = u_q.ah;
  assign lnk.block_mode[ID] = blk_mode;
  assign lnk.unit_ack[ID] = u_q.ack;
  assign lnk.unit_data[ID] = u_q.txd;
  assign lnk.unit_addr[ID] = u_q.ah ? u_q.ah_addr : u_q.ta;
endmodule // btio_unit

// [sim/btio_props.sv]
// Link and bus properties watched beside the channel-to-unit interface.
module btio_props (
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // Bus and memory side
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       mem_req,
  input wire logic       mem_grant,
  input wire logic       mem_we,
  // Link side
  input wire logic [1:0] data_avail,
  input wire logic [1:0] xfer_req,
  input wire logic [1:0] accepted,
  input wire logic [1:0] data_here,
  input wire logic [1:0] unit_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_acc_pulse; accepted[0] |=> !accepted[0]; endproperty
  a_acc_pulse: assert property (p_acc_pulse) else $error("accepted longer than one cycle");
  property p_acc_cause; accepted[0] |-> $past(data_avail[0] | xfer_req[0]); endproperty
  a_acc_cause: assert property (p_acc_cause) else $error("accepted without a word");
  property p_ack_pulse; unit_ack[0] |=> !unit_ack[0]; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("unit ack not a pulse");
  property p_ack_cause; unit_ack[0] |-> $past(data_here[0]); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without data here");
  property p_dh_drop; data_here[0] && unit_ack[0] |=> !data_here[0]; endproperty
  a_dh_drop: assert property (p_dh_drop) else $error("data here kept after ack");
  property p_req_hold; mem_req && !mem_grant |=> mem_req; endproperty
  a_req_hold: assert property (p_req_hold) else $error("memory request dropped");
  property p_rdy_setup; psel && !penable |=> pready ##1 !pready; endproperty
  a_rdy_setup: assert property (p_rdy_setup) else $error("bus answer timing wrong");
  property p_rdy_sel; pready |-> psel && penable; endproperty
  a_rdy_sel: assert property (p_rdy_sel) else $error("ready outside access");
  c_hs: cover property (data_here[0] && unit_ack[0]);
  c_acc: cover property (accepted[0]);
  c_wr: cover property (mem_grant && mem_we);
endmodule // btio_props

// [sim/block_transfer_io_channels_tb.sv]
// Self-checking bench joining the channel and one unit.
module block_transfer_io_channels_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import btio_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sl;
  logic        mem_req, mem_we, mem_grant, tx_valid, tx_ready, rx_valid;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [17:0] mem_addr;
  logic [23:0] mem_wdata, mem_rdata, tx_data, rx_data, mem [64];
  btio_kind_t  rx_kind;
  btio_var_t   mode = BTIO_VAR_SELF;
  logic [25:0] rxq [$];
  int          mismatches, n_checks;
  btio_if lnk ();
  assign lnk.data_avail[1] = 1'b0, lnk.xfer_req[1] = 1'b0, lnk.dir_in[1] = 1'b0;
  assign lnk.addr_here[1] = 1'b0, lnk.block_mode[1] = 1'b0, lnk.unit_ack[1] = 1'b0;
  assign lnk.unit_data[1] = 24'h00_0000, lnk.unit_addr[1] = 18'h0_0000;
  assign mem_rdata = mem[mem_addr[5:0]];
  btio_channel btio_channel_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_grant(mem_grant), .mem_rdata(mem_rdata), .lnk(lnk));
  btio_unit btio_unit_i (.pclk(pclk), .presetn(presetn), .ctl_mode(mode),
    .req_out(1'b0), .blk_mode(1'b0), .ext_addr_valid(1'b0), .ext_addr(18'h0_0000),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_kind(rx_kind), .wc_done(), .lnk(lnk));
  btio_props btio_props_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .mem_req(mem_req), .mem_grant(mem_grant), .mem_we(mem_we),
    .data_avail(lnk.data_avail), .xfer_req(lnk.xfer_req), .accepted(lnk.accepted),
    .data_here(lnk.data_here), .unit_ack(lnk.unit_ack));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Memory grants every other cycle so back-to-back requests see a stall.
  always @(posedge pclk) begin
    mem_grant <= mem_req && !mem_grant;
    if (mem_req && mem_grant && mem_we) mem[mem_addr[5:0]] <= mem_wdata;
    if (rx_valid === 1'b1) rxq.push_back({rx_kind, rx_data});
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    sl = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic busy_wait;
    do apb(1'b0, 8'h18, 32'h0); while (rd[0] !== 1'b0);
  endtask
  task automatic send(input logic [23:0] d);
    @(posedge pclk);
    {tx_valid, tx_data} <= {1'b1, d};
    do @(posedge pclk); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
  endtask
  task automatic t_regs;
    apb(1'b0, 8'h18, 32'h0); chk(rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0); chk(sl, 1'b1);
    apb(1'b1, 8'h00, 32'h8); apb(1'b0, 8'h14, 32'h0); chk(rd, 32'h8);
    apb(1'b1, 8'h1C, 32'h1); apb(1'b0, 8'h10, 32'h0); chk(rd, 32'h0);
    apb(1'b0, 8'h18, 32'h0); chk(rd[1], 1'b1);
    apb(1'b1, 8'h1C, 32'h0);
    $display("t_regs done");
  endtask
  task automatic t_out;
    rxq.delete();
    apb(1'b1, 8'h00, 32'h8); apb(1'b1, 8'h04, 32'h80_0000); busy_wait;
    chk(rxq.size(), 3);
    chk(rxq[0], {BTIO_KIND_CMD, 24'h80_0000});
    chk(rxq[1], {BTIO_KIND_DATA, 24'h5A_0010});
    chk(rxq[2], {BTIO_KIND_DATA, 24'h5A_0011});
    apb(1'b0, 8'h10, 32'h0); chk(rd, 32'h12);
    $display("t_out done");
  endtask
  task automatic t_in;
    // The refused write lands while the channel is still fetching its parameter words.
    apb(1'b1, 8'h00, 32'hC); apb(1'b1, 8'h04, 32'hC0_0000);
    apb(1'b1, 8'h08, 32'h1); apb(1'b0, 8'h18, 32'h0); chk(rd[1:0], 2'b11);
    send(24'h11_1111); send(24'h22_2222); send(24'h33_3333); busy_wait;
    chk(mem[32], 24'h22_2222);
    chk(mem[33], 24'h33_3333);
    chk(mem[34], 24'h5A_0022);
    apb(1'b0, 8'h10, 32'h0); chk(rd, 32'h22);
    $display("t_in done");
  endtask
  task automatic t_unit;
    mode <= BTIO_VAR_UNIT;
    apb(1'b1, 8'h1C, 32'h1);
    apb(1'b1, 8'h00, 32'h28); busy_wait;
    apb(1'b1, 8'h08, 32'h1); busy_wait;
    send(24'h77_7777); busy_wait;
    chk(mem[40], 24'h77_7777);
    $display("t_unit done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, tx_valid, tx_data} = '0;
    mismatches = 0;
    n_checks = 0;
    for (int i = 0; i < 64; i++) mem[i] = 24'h5A_0000 + 24'(i);
    {mem[8], mem[9], mem[12], mem[13]} = {24'h00_0002, 24'h00_0010, 24'h01_0002, 24'h00_0020};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_out;
    t_in;
    t_unit;
    tally_and_finish;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    tally_and_finish;
  end
endmodule // block_transfer_io_channels_tb
